//--- inc/acau_pkg.sv
// Shared constants and types for the accumulator compare and add unit.
// Assumes one clock domain and a same-clock instruction sequencer.
package acau_pkg;

  localparam int DW    = 32;
  localparam int HW    = 16;
  localparam int RAW   = 4;
  localparam int DIG_W = 4;
  localparam int W_DIG = HW / DIG_W;
  localparam int D_DIG = DW / DIG_W;

  // Register indices on the plain register port
  localparam logic [RAW-1:0] REG_ACC      = 4'h0;
  localparam logic [RAW-1:0] REG_FLAGS    = 4'h1;
  localparam logic [RAW-1:0] REG_IRQ_STAT = 4'h2;
  localparam logic [RAW-1:0] REG_IRQ_MASK = 4'h3;

  localparam logic [DW-1:0] ACC_RST = 32'h0000_0000;

  // BCD digit limits
  localparam logic [4:0] BCD_MAX = 5'h09;
  localparam logic [4:0] BCD_ADJ = 5'h06;

  // Single precision layout
  localparam logic [7:0] EXP_MAX = 8'hFF;
  localparam logic [7:0] EXP_ONE = 8'h01;
  localparam logic [7:0] SH_MAX  = 8'h1A;
  localparam int         NRM_MAX = 26;

  // Interrupt status bit positions
  localparam int IRQ_BADPTR = 0;
  localparam int IRQ_INVAL  = 1;
  localparam int IRQ_C16    = 2;
  localparam int IRQ_C32    = 3;
  localparam int IRQ_W      = 4;

  typedef enum logic [6:0] {
    COMPARE_WORD_OP      = 7'h01,
    COMPARE_DOUBLE_OP    = 7'h02,
    COMPARE_BIT_FIELD_OP = 7'h04,
    COMPARE_REAL_OP      = 7'h08,
    ADD_WORD_OP          = 7'h10,
    ADD_DOUBLE_OP        = 7'h20,
    ADD_REAL_OP          = 7'h40
  } acau_opc_t;

  typedef enum logic [2:0] {
    SRC_MEM   = 3'h1,
    SRC_PTR   = 3'h2,
    SRC_CONST = 3'h4
  } acau_src_t;

  typedef struct packed {
    logic       valid;
    logic       enable;
    acau_opc_t  code;
    acau_src_t  src;
    logic       ptr_ok;
    logic [5:0] nbits;
    logic [31:0] data;
  } acau_op_t;

  typedef struct packed {
    logic inval;
    logic badptr;
    logic neg;
    logic c32;
    logic c16;
    logic zero;
    logic gt;
    logic eq;
    logic lt;
  } acau_flags_t;

  localparam int FLAG_W = $bits(acau_flags_t);

endpackage

//--- core/acau_core.sv
// Accumulator datapath: compares, BCD adds and real add with status flags.
// Assumes operations arrive from same-clock sequencer logic, one per cycle.
//
// Summary of operation
// - Compare raises less, equal or greater flag
// - Flags hold until next op driving them
// - Word compare uses low 16 accumulator bits
// - Double compare uses full 32-bit accumulator
// - Field compare masks 1 to 32 bits
// - Real compare orders two 32-bit reals
// - Invalid pointer sets bad pointer flag
// - Non-real operand sets invalid operand flag
// - Word add sums BCD into accumulator
// - Add sets zero flag on zero result
// - Four digit overflow sets carry16 flag
// - Eight digit overflow sets carry32 flag
// - Add sets negative flag from sign bit
// - Non-BCD digit sets invalid operand flag
// - Double add sums eight BCD digits
// - Real add sums single precision operands
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ns

module acau_core (
  input  wire logic                     MCLK,
  input  wire logic                     RESETN,
  input  wire acau_pkg::acau_op_t       OP,
  input  wire logic [acau_pkg::RAW-1:0] BUS_ADDR,
  input  wire logic [acau_pkg::DW-1:0]  BUS_WDATA,
  input  wire logic                     BUS_WR,
  input  wire logic                     BUS_RD,
  output logic [acau_pkg::DW-1:0]       BUS_RDATA,
  output logic [acau_pkg::DW-1:0]       ACC,
  output acau_pkg::acau_flags_t         FLAGS,
  output logic                          IRQ
);
  import acau_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Returns {gt, eq, lt} of unsigned a against b
  function automatic logic [2:0] rel(input logic [31:0] a,
                                     input logic [31:0] b);
    return {a > b, a == b, a < b};
  endfunction

  // Ordered key so reals compare as unsigned; both zeros map alike
  function automatic logic [31:0] f_key(input logic [31:0] a);
    if (a[30:0] == '0) begin
      return 32'h8000_0000;
    end
    return a[31] ? ~a : (a ^ 32'h8000_0000);
  endfunction

  function automatic logic f_bad(input logic [31:0] a);
    return a[30:23] == EXP_MAX;
  endfunction

  function automatic logic [31:0] fmask(input logic [5:0] n);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < DW; i++) begin
      m[i] = (i < int'(n));
    end
    return m;
  endfunction

  function automatic logic bcd_ok(input logic [31:0] a, input int nd);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < D_DIG; i++) begin
      if (i < nd && {1'b0, a[DIG_W*i +: DIG_W]} > BCD_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Returns {carry, sum} over nd decimal digits
  function automatic logic [32:0] bcd_add(input logic [31:0] a,
                                          input logic [31:0] b,
                                          input int          nd);
    logic [32:0] r;
    logic        c;
    logic [4:0]  s;
    r = '0;
    c = 1'b0;
    s = '0;
    for (int i = 0; i < D_DIG; i++) begin
      if (i < nd) begin
        s = {1'b0, a[DIG_W*i +: DIG_W]} + {1'b0, b[DIG_W*i +: DIG_W]}
            + {4'h0, c};
        c = (s > BCD_MAX);
        if (c) begin
          s = s + BCD_ADJ;
        end
        r[DIG_W*i +: DIG_W] = s[3:0];
      end
    end
    r[DW] = c;
    return r;
  endfunction

  // Truncating single precision add; denormals keep hidden bit clear
  function automatic logic [31:0] f_add(input logic [31:0] x,
                                        input logic [31:0] y);
    logic [31:0] a;
    logic [31:0] b;
    logic [7:0]  e;
    logic [7:0]  d;
    logic [26:0] ma;
    logic [26:0] mb;
    logic [27:0] s;
    if (x[30:0] >= y[30:0]) begin
      a = x;
      b = y;
    end else begin
      a = y;
      b = x;
    end
    ma = {|a[30:23], a[22:0], 3'h0};
    mb = {|b[30:23], b[22:0], 3'h0};
    d  = a[30:23] - b[30:23];
    mb = (d > SH_MAX) ? '0 : (mb >> d);
    s  = (a[31] == b[31]) ? ({1'b0, ma} + {1'b0, mb})
                          : ({1'b0, ma} - {1'b0, mb});
    e  = a[30:23];
    if (s[27]) begin
      s = s >> 1;
      e = e + EXP_ONE;
    end else begin
      for (int i = 0; i < NRM_MAX; i++) begin
        if (!s[26] && e > EXP_ONE && s != '0) begin
          s = s << 1;
          e = e - EXP_ONE;
        end
      end
    end
    if (s == '0) begin
      return '0;
    end
    if (e == EXP_MAX) begin
      return {a[31], EXP_MAX, 23'h0};
    end
    return {a[31], s[26] ? e : 8'h00, s[25:3]};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State

  logic [DW-1:0]     acc_q;
  logic [DW-1:0]     acc_d;
  acau_flags_t       flg_q;
  acau_flags_t       flg_d;
  logic [IRQ_W-1:0]  stat_q;
  logic [IRQ_W-1:0]  stat_d;
  logic [IRQ_W-1:0]  mask_q;
  logic [IRQ_W-1:0]  mask_d;
  logic [IRQ_W-1:0]  ev;
  logic              irq_q;
  logic [DW-1:0]     rdata_q;
  logic              upd_zn;

  ////////////////////////////////////////////////////////////////////
  // Operand decode and datapath

  wire        op_go    = OP.valid && OP.enable;
  wire        ptr_bad  = (OP.src == SRC_PTR) && !OP.ptr_ok;
  wire        acc_wr   = BUS_WR && (BUS_ADDR == REG_ACC);
  wire [31:0] acc_lo   = {16'h0000, acc_q[HW-1:0]};
  wire [31:0] opd_lo   = {16'h0000, OP.data[HW-1:0]};
  wire [31:0] fld      = OP.data & fmask(OP.nbits);
  wire [2:0]  rel_w    = rel(acc_lo, opd_lo);
  wire [2:0]  rel_d    = rel(acc_q, OP.data);
  wire [2:0]  rel_f    = rel(acc_q, fld);
  wire [2:0]  rel_r    = rel(f_key(acc_q), f_key(OP.data));
  wire        real_bad = f_bad(acc_q) || f_bad(OP.data);
  wire        w_ok     = bcd_ok(acc_lo, W_DIG) && bcd_ok(opd_lo, W_DIG);
  wire        d_ok     = bcd_ok(acc_q, D_DIG) && bcd_ok(OP.data, D_DIG);
  wire [32:0] sum_w    = bcd_add(acc_q, OP.data, W_DIG);
  wire [32:0] sum_d    = bcd_add(acc_q, OP.data, D_DIG);
  wire [31:0] sum_r    = f_add(acc_q, OP.data);
  wire        is_cmp   = OP.code inside {COMPARE_WORD_OP, COMPARE_DOUBLE_OP,
                                         COMPARE_BIT_FIELD_OP, COMPARE_REAL_OP};

  // Bus writes to the accumulator lose to an add that updates it in the same cycle
  always_comb begin
    acc_d  = acc_wr ? BUS_WDATA : acc_q;
    flg_d  = flg_q;
    ev     = '0;
    upd_zn = 1'b0;
    if (op_go) begin
      if (ptr_bad) begin
        flg_d.badptr   = 1'b1;
        ev[IRQ_BADPTR] = 1'b1;
      end else begin
        if (OP.src == SRC_PTR) begin
          flg_d.badptr = 1'b0;
        end
        unique case (OP.code)
          COMPARE_WORD_OP: begin
            {flg_d.gt, flg_d.eq, flg_d.lt} = rel_w;
          end
          COMPARE_DOUBLE_OP: begin
            {flg_d.gt, flg_d.eq, flg_d.lt} = rel_d;
          end
          COMPARE_BIT_FIELD_OP: begin
            {flg_d.gt, flg_d.eq, flg_d.lt} = rel_f;
          end
          COMPARE_REAL_OP: begin
            flg_d.inval = real_bad;
            ev[IRQ_INVAL] = real_bad;
            if (!real_bad) begin
              {flg_d.gt, flg_d.eq, flg_d.lt} = rel_r;
            end
          end
          ADD_WORD_OP: begin
            flg_d.inval = !w_ok;
            ev[IRQ_INVAL] = !w_ok;
            if (w_ok) begin
              acc_d       = {16'h0000, sum_w[HW-1:0]};
              flg_d.c16   = sum_w[DW];
              ev[IRQ_C16] = sum_w[DW];
              upd_zn      = 1'b1;
            end
          end
          ADD_DOUBLE_OP: begin
            flg_d.inval = !d_ok;
            ev[IRQ_INVAL] = !d_ok;
            if (d_ok) begin
              acc_d       = sum_d[DW-1:0];
              flg_d.c32   = sum_d[DW];
              ev[IRQ_C32] = sum_d[DW];
              upd_zn      = 1'b1;
            end
          end
          ADD_REAL_OP: begin
            flg_d.inval = real_bad;
            ev[IRQ_INVAL] = real_bad;
            if (!real_bad) begin
              acc_d  = sum_r;
              upd_zn = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (upd_zn) begin
      flg_d.zero = (acc_d[30:0] == '0) && (OP.code == ADD_REAL_OP || !acc_d[31]);
      flg_d.neg  = acc_d[31];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register port and interrupt

  // Set wins over a write-one clear in the same cycle
  wire [IRQ_W-1:0] stat_clr = (BUS_WR && BUS_ADDR == REG_IRQ_STAT)
                              ? BUS_WDATA[IRQ_W-1:0] : '0;
  wire             mask_wr  = BUS_WR && (BUS_ADDR == REG_IRQ_MASK);
  wire [DW-1:0]    rd_mux   =
    (BUS_ADDR == REG_ACC)      ? acc_q :
    (BUS_ADDR == REG_FLAGS)    ? {{(DW-FLAG_W){1'b0}}, flg_q} :
    (BUS_ADDR == REG_IRQ_STAT) ? {{(DW-IRQ_W){1'b0}}, stat_q} :
    (BUS_ADDR == REG_IRQ_MASK) ? {{(DW-IRQ_W){1'b0}}, mask_q} : '0;

  assign stat_d = (stat_q & ~stat_clr) | ev;
  assign mask_d = mask_wr ? BUS_WDATA[IRQ_W-1:0] : mask_q;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      acc_q   <= ACC_RST;
      flg_q   <= '0;
      stat_q  <= '0;
      mask_q  <= '0;
      irq_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      acc_q   <= acc_d;
      flg_q   <= flg_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      irq_q   <= |(stat_d & mask_d);
      rdata_q <= BUS_RD ? rd_mux : '0;
    end
  end

  assign ACC       = acc_q;
  assign FLAGS     = flg_q;
  assign IRQ       = irq_q;
  assign BUS_RDATA = rdata_q;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);

  wire go_ok = op_go && !ptr_bad;

  sequence s_add_done;
    go_ok && upd_zn;
  endsequence

  sequence s_word_cmp;
    go_ok && OP.code == COMPARE_WORD_OP;
  endsequence

  property p_idle;
    (OP.valid && !OP.enable && !acc_wr) |=> $stable(acc_q) && $stable(flg_q);
  endproperty
  a_idle: assert property (p_idle) else $error("disabled op changed state");

  property p_hold;
    !OP.valid |=> $stable(flg_q);
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved with no op");

  property p_cmp_acc;
    (go_ok && is_cmp && !acc_wr) |=> $stable(acc_q);
  endproperty
  a_cmp_acc: assert property (p_cmp_acc) else $error("compare wrote acc");

  property p_word_lt;
    (s_word_cmp and (acc_q[HW-1:0] < OP.data[HW-1:0]))
      |=> flg_q.lt && !flg_q.eq && !flg_q.gt;
  endproperty
  a_word_lt: assert property (p_word_lt) else $error("word less wrong");

  property p_dbl_eq;
    (go_ok && OP.code == COMPARE_DOUBLE_OP && acc_q == OP.data)
      |=> flg_q.eq && !flg_q.lt && !flg_q.gt;
  endproperty
  a_dbl_eq: assert property (p_dbl_eq) else $error("double equal wrong");

  property p_fld_gt;
    (go_ok && OP.code == COMPARE_BIT_FIELD_OP && acc_q > fld)
      |=> flg_q.gt && !flg_q.eq && !flg_q.lt;
  endproperty
  a_fld_gt: assert property (p_fld_gt) else $error("field greater wrong");

  property p_real_cmp;
    (go_ok && OP.code == COMPARE_REAL_OP && !real_bad)
      |=> {flg_q.gt, flg_q.eq, flg_q.lt} == $past(rel_r) && !flg_q.inval;
  endproperty
  a_real_cmp: assert property (p_real_cmp) else $error("real compare wrong");

  property p_real_bad;
    (go_ok && OP.code inside {COMPARE_REAL_OP, ADD_REAL_OP} && real_bad && !acc_wr)
      |=> flg_q.inval && $stable(acc_q);
  endproperty
  a_real_bad: assert property (p_real_bad) else $error("bad real missed");

  property p_ptr;
    (op_go && ptr_bad && !acc_wr) |=> flg_q.badptr && $stable(acc_q) && stat_q[IRQ_BADPTR];
  endproperty
  a_ptr: assert property (p_ptr) else $error("bad pointer missed");

  property p_add_w;
    (go_ok && OP.code == ADD_WORD_OP && w_ok)
      |=> acc_q == {16'h0000, $past(sum_w[HW-1:0])} && flg_q.c16 == $past(sum_w[DW]);
  endproperty
  a_add_w: assert property (p_add_w) else $error("word add wrong");

  property p_add_d;
    (go_ok && OP.code == ADD_DOUBLE_OP && d_ok)
      |=> acc_q == $past(sum_d[DW-1:0]) && flg_q.c32 == $past(sum_d[DW]);
  endproperty
  a_add_d: assert property (p_add_d) else $error("double add wrong");

  property p_zn;
    s_add_done |=> flg_q.neg == acc_q[31] && (flg_q.zero -> acc_q[30:0] == '0)
                   && (acc_q == '0 -> flg_q.zero);
  endproperty
  a_zn: assert property (p_zn) else $error("zero or negative wrong");

  property p_bcd_bad;
    (go_ok && OP.code inside {ADD_WORD_OP, ADD_DOUBLE_OP}
      && !(OP.code == ADD_WORD_OP ? w_ok : d_ok) && !acc_wr) |=> flg_q.inval && $stable(acc_q);
  endproperty
  a_bcd_bad: assert property (p_bcd_bad) else $error("non-BCD missed");

  property p_radd;
    (go_ok && OP.code == ADD_REAL_OP && !real_bad) |=> acc_q == $past(sum_r);
  endproperty
  a_radd: assert property (p_radd) else $error("real add wrong");

endmodule // acau_core

//--- verification/acau_seq_model.sv
// Instruction sequencer model: presents one operation at a time on the op port.
// Assumes the same clock as the datapath; the bench calls issue() hierarchically.
`timescale 1ns/1ns

module acau_seq_model (
  input  wire logic         mclk,
  output acau_pkg::acau_op_t op
);
  import acau_pkg::*;

  initial begin
    op = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Real operands arrive as formatted by the caller; bad ones only on purpose
  task automatic issue(input acau_opc_t c, input acau_src_t s, input logic pk,
                       input logic [5:0] nb, input logic [31:0] d, input logic en);
    @(posedge mclk);
    op.valid  <= 1'b1;
    op.enable <= en;
    op.code   <= c;
    op.src    <= s;
    op.ptr_ok <= pk;
    op.nbits  <= nb;
    op.data   <= d;
    @(posedge mclk);
    op.valid  <= 1'b0;
    // Stale operand never left standing
    op.data   <= ~d;
  endtask
endmodule // acau_seq_model

//--- verification/tb_accumulator_compare_add_unit.sv
// Self-checking bench for the accumulator compare and add unit.
// Assumes the sequencer model drives the op port and the bench owns the register port.
`timescale 1ns/1ns

module tb_accumulator_compare_add_unit;
  import acau_pkg::*;

  logic              mclk;
  logic              resetn;
  acau_op_t          seq_op;
  logic [RAW-1:0]    bus_addr;
  logic [DW-1:0]     bus_wdata;
  logic              bus_wr;
  logic              bus_rd;
  logic [DW-1:0]     bus_rdata;
  logic [DW-1:0]     acc;
  acau_flags_t       flags;
  logic              irq;
  int                n_mismatch;
  int                comparisons;
  int                cycles = 0;

  acau_seq_model i_seq (.mclk(mclk), .op(seq_op));

  acau_core i_dut (
    .MCLK(mclk), .RESETN(resetn), .OP(seq_op), .BUS_ADDR(bus_addr),
    .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr), .BUS_RD(bus_rd),
    .BUS_RDATA(bus_rdata), .ACC(acc), .FLAGS(flags), .IRQ(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("mismatches %0d of %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Hang guard: whole sequence needs about a hundred cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [RAW-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr    <= 1'b0;
    bus_wdata <= ~d;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [RAW-1:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd   <= 1'b0;
    #1;
    check("read data", exp, bus_rdata);
    // Data must drop back to zero one cycle later
    @(posedge mclk);
    #1;
    check("read idle", 32'h0, bus_rdata);
  endtask

  task automatic opx(input acau_opc_t c, input acau_src_t s, input logic pk,
                     input logic [5:0] nb, input logic [31:0] d, input logic en,
                     input logic [31:0] ea, input logic [31:0] ef);
    i_seq.issue(c, s, pk, nb, d, en);
    #1;
    check("accumulator", ea, acc);
    check("flags", ef, {23'h0, flags});
  endtask

  task automatic op(input acau_opc_t c, input logic [31:0] d, input logic [31:0] ea,
                    input logic [31:0] ef);
    opx(c, SRC_MEM, 1'b1, 6'h20, d, 1'b1, ea, ef);
  endtask

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge mclk);
    #1;
    check("interrupt", {31'h0, exp}, {31'h0, irq});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn      = 1'b0;
    bus_addr    = '0;
    bus_wdata   = '0;
    bus_wr      = 1'b0;
    bus_rd      = 1'b0;
    n_mismatch  = 0;
    comparisons = 0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    rd(REG_FLAGS, 32'h0);
    wr(REG_ACC, 32'h0000_9999);
    op(ADD_WORD_OP, 32'h0000_0001, 32'h0, 32'h018);
    wr(REG_ACC, 32'h1234_5678);
    op(COMPARE_WORD_OP, 32'h0000_5678, 32'h1234_5678, 32'h01A);
    // Low half less although the full word is greater
    op(COMPARE_WORD_OP, 32'h0000_5679, 32'h1234_5678, 32'h019);
    op(COMPARE_DOUBLE_OP, 32'h1234_5679, 32'h1234_5678, 32'h019);
    op(COMPARE_DOUBLE_OP, 32'h1234_5677, 32'h1234_5678, 32'h01C);
    wr(REG_ACC, 32'h0000_0006);
    opx(COMPARE_BIT_FIELD_OP, SRC_MEM, 1'b1, 6'h04, 32'hFFFF_FFF6, 1'b1, 6, 32'h01A);
    opx(COMPARE_BIT_FIELD_OP, SRC_MEM, 1'b1, 6'h20, 32'hFFFF_FFF6, 1'b1, 6, 32'h019);
    opx(COMPARE_BIT_FIELD_OP, SRC_MEM, 1'b1, 6'h02, 32'hFFFF_FFF6, 1'b1, 6, 32'h01C);
    // 7.0 against 6.0, an infinity, then -6.0
    wr(REG_ACC, 32'h40E0_0000);
    op(COMPARE_REAL_OP, 32'h40C0_0000, 32'h40E0_0000, 32'h01C);
    op(COMPARE_REAL_OP, 32'h7F80_0000, 32'h40E0_0000, 32'h11C);
    op(COMPARE_REAL_OP, 32'hC0C0_0000, 32'h40E0_0000, 32'h01C);
    op(ADD_REAL_OP, 32'h3F80_0000, 32'h4100_0000, 32'h014);
    op(ADD_WORD_OP, 32'h0000_000A, 32'h4100_0000, 32'h114);
    opx(ADD_DOUBLE_OP, SRC_MEM, 1'b1, 6'h20, 32'h1, 1'b0, 32'h4100_0000, 32'h114);
    wr(REG_ACC, 32'h9999_9999);
    op(ADD_DOUBLE_OP, 32'h0000_0001, 32'h0, 32'h03C);
    op(ADD_DOUBLE_OP, 32'h8000_0000, 32'h8000_0000, 32'h054);
    opx(COMPARE_WORD_OP, SRC_PTR, 1'b0, 6'h20, 32'h0, 1'b1, 32'h8000_0000, 32'h0D4);
    opx(COMPARE_DOUBLE_OP, SRC_PTR, 1'b1, 6'h20, 32'h8000_0000, 1'b1,
        32'h8000_0000, 32'h052);
    // Event status: pointer, operand, both carries
    rd(REG_IRQ_STAT, 32'hF);
    irq_is(1'b0);
    wr(REG_IRQ_MASK, 32'h1);
    irq_is(1'b1);
    wr(REG_IRQ_STAT, 32'h1);
    irq_is(1'b0);
    rd(REG_IRQ_STAT, 32'hE);
    rd(REG_IRQ_MASK, 32'h1);
    wr(REG_FLAGS, 32'h0);
    rd(REG_FLAGS, 32'h052);
    rd(4'hF, 32'h0);
    rd(REG_ACC, 32'h8000_0000);
    complete_run();
  end
endmodule // tb_accumulator_compare_add_unit
